// ---- verilog/ccv_pkg.sv ----
package ccv_pkg;

  // ----------------------------------------------------------------
  // Register offsets and values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_FAST = 8'h02;
  localparam logic [7:0] ADDR_PRE = 8'h03;
  localparam logic [7:0] ADDR_VOLT = 8'h04;
  localparam logic [7:0] RST_FAST = 8'h60;
  localparam logic [7:0] RST_PRE = 8'h11;
  localparam logic [7:0] RST_VOLT = 8'hB2;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FAST_MSB = 7;
  localparam int FAST_LSB = 2;
  localparam int BCOLD_BIT = 1;
  localparam int OVERRIDE_BIT = 0;
  localparam int PRE_MSB = 7;
  localparam int PRE_LSB = 4;
  localparam int TERM_MSB = 2;
  localparam int TERM_LSB = 0;
  localparam int VOLT_MSB = 7;
  localparam int VOLT_LSB = 2;
  localparam int LOWV_BIT = 1;
  localparam int RECHG_BIT = 0;

  // ----------------------------------------------------------------
  // Decode constants, currents in mA, voltages in mV
  // ----------------------------------------------------------------
  localparam logic [12:0] FAST_BASE_MA = 13'h0200;
  localparam logic [12:0] FAST_STEP_MA = 13'h0040;
  localparam logic [5:0] FAST_MAX_CODE = 6'h27;
  localparam logic [12:0] FAST_SCALE_DIV = 13'h0005;
  localparam logic [12:0] TERM_BASE_MA = 13'h0080;
  localparam logic [12:0] TERM_STEP_MA = 13'h0080;
  localparam logic [12:0] VOLT_BASE_MV = 13'h0DB0;
  localparam logic [12:0] VOLT_STEP_MV = 13'h0010;
  localparam logic [12:0] VOLT_MAX_MV = 13'h1130;
  localparam logic [6:0] BCOLD0_PCT = 7'h4C;
  localparam logic [6:0] BCOLD1_PCT = 7'h4F;
  localparam logic [12:0] LOWV0_MV = 13'h0AF0;
  localparam logic [12:0] LOWV1_MV = 13'h0BB8;
  localparam logic [8:0] RECHG0_MV = 9'h064;
  localparam logic [8:0] RECHG1_MV = 9'h12C;

  // Pre-charge lookup, index 0 first
  localparam logic [12:0] PRE_LUT [16] = '{
    13'h0080, 13'h0080, 13'h0100, 13'h0180,
    13'h0200, 13'h0300, 13'h0380, 13'h0400,
    13'h0480, 13'h0500, 13'h0580, 13'h0600,
    13'h0680, 13'h0700, 13'h0780, 13'h0800
  };

endpackage : ccv_pkg

// ---- verilog/ccv_target_if.sv ----
// --------------------------------------------------------------------
// Register contents out, decoded targets back
// --------------------------------------------------------------------
interface ccv_target_if;
  logic [7:0] fast_reg;
  logic [7:0] pre_reg;
  logic [7:0] volt_reg;
  logic [12:0] fast_ma;
  logic [12:0] pre_ma;
  logic [12:0] term_ma;
  logic [12:0] volt_mv;
  logic [12:0] lowv_mv;
  logic [8:0] rechg_mv;
  logic [6:0] bcold_pct;

  modport regs (
    output fast_reg, pre_reg, volt_reg,
    input fast_ma, pre_ma, term_ma, volt_mv, lowv_mv, rechg_mv, bcold_pct
  );
  modport dec (
    input fast_reg, pre_reg, volt_reg,
    output fast_ma, pre_ma, term_ma, volt_mv, lowv_mv, rechg_mv, bcold_pct
  );
endinterface : ccv_target_if

// ---- verilog/ccv_decode.sv ----
module ccv_decode (
  ccv_target_if.dec tgt
);
  import ccv_pkg::*;

  // ------------------------------------------------------------------
  // Combinational field decode
  // ------------------------------------------------------------------
  logic [12:0] fast_raw;
  logic [12:0] pre_raw;
  logic [12:0] volt_raw;

  // Fast-charge and pre-charge before scaling
  always_comb begin
    fast_raw = FAST_BASE_MA
      + 13'(tgt.fast_reg[FAST_MSB:FAST_LSB]) * FAST_STEP_MA;
    pre_raw = PRE_LUT[tgt.pre_reg[PRE_MSB:PRE_LSB]];
  end

  // Reduced-current override scales both targets
  always_comb begin
    if (tgt.fast_reg[OVERRIDE_BIT]) begin
      tgt.fast_ma = fast_raw / FAST_SCALE_DIV;
      tgt.pre_ma = {1'b0, pre_raw[12:1]};
    end else begin
      tgt.fast_ma = fast_raw;
      tgt.pre_ma = pre_raw;
    end
  end

  // Termination, voltage and threshold selects
  always_comb begin
    tgt.term_ma = TERM_BASE_MA
      + 13'(tgt.pre_reg[TERM_MSB:TERM_LSB]) * TERM_STEP_MA;
    volt_raw = VOLT_BASE_MV
      + 13'(tgt.volt_reg[VOLT_MSB:VOLT_LSB]) * VOLT_STEP_MV;
    tgt.volt_mv = (volt_raw > VOLT_MAX_MV) ? VOLT_MAX_MV
                                           : volt_raw;
    tgt.bcold_pct = tgt.fast_reg[BCOLD_BIT] ? BCOLD1_PCT
                                            : BCOLD0_PCT;
    tgt.lowv_mv = tgt.volt_reg[LOWV_BIT] ? LOWV1_MV : LOWV0_MV;
    tgt.rechg_mv = tgt.volt_reg[RECHG_BIT] ? RECHG1_MV
                                           : RECHG0_MV;
  end

endmodule : ccv_decode

// ---- verilog/ccv_regs.sv ----
module ccv_regs (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  output logic [12:0] fast_chg_current_target_out,
  output logic [12:0] precharge_current_target_out,
  output logic [12:0] termination_current_target_out,
  output logic [12:0] charge_voltage_target_out,
  output logic [12:0] low_batt_thresh_out,
  output logic [8:0] recharge_offset_out,
  output logic [6:0] boost_cold_thresh_pct_out
);
  import ccv_pkg::*;

  // ------------------------------------------------------------------
  // Register storage
  // ------------------------------------------------------------------
  ccv_target_if tgt ();

  logic wr_fast;
  logic wr_pre;
  logic wr_volt;

  // Write decode
  assign wr_fast = reg_wr_in && (reg_addr_in == ADDR_FAST);
  assign wr_pre = reg_wr_in && (reg_addr_in == ADDR_PRE);
  assign wr_volt = reg_wr_in && (reg_addr_in == ADDR_VOLT);

  // Fast-charge current register
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      tgt.fast_reg <= RST_FAST;
    end else if (wr_fast) begin
      tgt.fast_reg <= reg_wdata_in;
    end
  end

  // Pre-charge and termination register, reserved bit kept as written
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      tgt.pre_reg <= RST_PRE;
    end else if (wr_pre) begin
      tgt.pre_reg <= reg_wdata_in;
    end
  end

  // Charge-voltage register
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      tgt.volt_reg <= RST_VOLT;
    end else if (wr_volt) begin
      tgt.volt_reg <= reg_wdata_in;
    end
  end

  // Read data, captured on a read strobe
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= RDATA_UNMAPPED;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        ADDR_FAST: reg_rdata_out <= tgt.fast_reg;
        ADDR_PRE: reg_rdata_out <= tgt.pre_reg;
        ADDR_VOLT: reg_rdata_out <= tgt.volt_reg;
        default: reg_rdata_out <= RDATA_UNMAPPED;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Decode and target outputs
  // ------------------------------------------------------------------
  ccv_decode u_decode (
    .tgt(tgt.dec)
  );

  // Targets refresh every cycle, one cycle after the register
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      fast_chg_current_target_out <= 13'h0000;
      precharge_current_target_out <= 13'h0000;
      termination_current_target_out <= 13'h0000;
      charge_voltage_target_out <= 13'h0000;
      low_batt_thresh_out <= 13'h0000;
      recharge_offset_out <= 9'h000;
      boost_cold_thresh_pct_out <= 7'h00;
    end else begin
      fast_chg_current_target_out <= tgt.fast_ma;
      precharge_current_target_out <= tgt.pre_ma;
      termination_current_target_out <= tgt.term_ma;
      charge_voltage_target_out <= tgt.volt_mv;
      low_batt_thresh_out <= tgt.lowv_mv;
      recharge_offset_out <= tgt.rechg_mv;
      boost_cold_thresh_pct_out <= tgt.bcold_pct;
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  // Register values after reset
  AST_FAST_RESET: assert property (
    $past(!rst_n_in) |-> tgt.fast_reg == RST_FAST)
    else $error("fast-charge register wrong after reset");

  AST_PRE_RESET: assert property (
    $past(!rst_n_in) |-> tgt.pre_reg == RST_PRE)
    else $error("pre-charge register wrong after reset");

  AST_VOLT_RESET: assert property (
    $past(!rst_n_in) |-> tgt.volt_reg == RST_VOLT)
    else $error("charge-voltage register wrong after reset");

  AST_FAST_DECODE: assert property (
    !$past(tgt.fast_reg[OVERRIDE_BIT]) && $past(rst_n_in)
    |-> fast_chg_current_target_out == FAST_BASE_MA
        + 13'($past(tgt.fast_reg[FAST_MSB:FAST_LSB])) * FAST_STEP_MA)
    else $error("fast-charge target decode wrong");

  AST_OVERRIDE: assert property (
    $past(tgt.fast_reg[OVERRIDE_BIT]) && $past(rst_n_in)
    |-> precharge_current_target_out
        == {1'b0, PRE_LUT[$past(tgt.pre_reg[PRE_MSB:PRE_LSB])][12:1]})
    else $error("override did not halve pre-charge target");

  AST_BCOLD: assert property (
    $past(rst_n_in) |-> boost_cold_thresh_pct_out
      == ($past(tgt.fast_reg[BCOLD_BIT]) ? BCOLD1_PCT : BCOLD0_PCT))
    else $error("boost cold threshold select wrong");

  AST_PRE_CODE5: assert property (
    $past(tgt.pre_reg[PRE_MSB:PRE_LSB]) == 4'h5
      && !$past(tgt.fast_reg[OVERRIDE_BIT]) && $past(rst_n_in)
    |-> precharge_current_target_out == 13'h0300)
    else $error("pre-charge code 0101 not 768 mA");

  AST_TERM: assert property (
    $past(rst_n_in) |-> termination_current_target_out == TERM_BASE_MA
      + 13'($past(tgt.pre_reg[TERM_MSB:TERM_LSB])) * TERM_STEP_MA)
    else $error("termination target decode wrong");

  AST_READBACK: assert property (
    wr_pre ##1 !wr_pre
    ##1 (reg_rd_in && reg_addr_in == ADDR_PRE && !reg_wr_in)
    |=> reg_rdata_out == $past(reg_wdata_in, 3))
    else $error("pre-charge register readback mismatch");

  AST_VOLT_MAX: assert property (
    charge_voltage_target_out <= VOLT_MAX_MV)
    else $error("charge voltage above ceiling");

  AST_LOWV_FOLLOW: assert property (
    wr_volt ##1 !wr_volt |=> low_batt_thresh_out
      == ($past(reg_wdata_in[LOWV_BIT], 2) ? LOWV1_MV : LOWV0_MV))
    else $error("low battery threshold not taken from write");

  AST_RECHG_FOLLOW: assert property (
    wr_volt ##1 !wr_volt |=> recharge_offset_out
      == ($past(reg_wdata_in[RECHG_BIT], 2) ? RECHG1_MV : RECHG0_MV))
    else $error("recharge offset not taken from write");

  // Override scaling, voltage decode and read port
  AST_FAST_OVERRIDE: assert property (
    $past(tgt.fast_reg[OVERRIDE_BIT]) && $past(rst_n_in)
    |-> fast_chg_current_target_out == (FAST_BASE_MA
        + 13'($past(tgt.fast_reg[FAST_MSB:FAST_LSB])) * FAST_STEP_MA)
        / FAST_SCALE_DIV)
    else $error("override did not scale fast-charge target");

  AST_VOLT_DECODE: assert property (
    $past(rst_n_in)
      && VOLT_BASE_MV
         + 13'($past(tgt.volt_reg[VOLT_MSB:VOLT_LSB])) * VOLT_STEP_MV
         <= VOLT_MAX_MV
    |-> charge_voltage_target_out == VOLT_BASE_MV
        + 13'($past(tgt.volt_reg[VOLT_MSB:VOLT_LSB])) * VOLT_STEP_MV)
    else $error("charge voltage target decode wrong");

  AST_PRE_CODE_LOW: assert property (
    $past(tgt.pre_reg[PRE_MSB:PRE_LSB]) <= 4'h1
      && !$past(tgt.fast_reg[OVERRIDE_BIT]) && $past(rst_n_in)
    |-> precharge_current_target_out == 13'h0080)
    else $error("pre-charge codes 0000 and 0001 not 128 mA");

  AST_PRE_CODE_TOP: assert property (
    $past(tgt.pre_reg[PRE_MSB:PRE_LSB]) == 4'hF
      && !$past(tgt.fast_reg[OVERRIDE_BIT]) && $past(rst_n_in)
    |-> precharge_current_target_out == 13'h0800)
    else $error("pre-charge code 1111 not 2048 mA");

  AST_RDATA_HOLD: assert property (
    $past(rst_n_in) && !$past(reg_rd_in) |-> $stable(reg_rdata_out))
    else $error("read data changed without a read strobe");

  AST_UNMAPPED_READ: assert property (
    $past(rst_n_in) && $past(reg_rd_in)
      && $past(reg_addr_in) != ADDR_FAST && $past(reg_addr_in) != ADDR_PRE
      && $past(reg_addr_in) != ADDR_VOLT
    |-> reg_rdata_out == RDATA_UNMAPPED)
    else $error("unmapped read did not return zero");

  // Scenario covers
  COV_OVERRIDE: cover property (wr_fast && reg_wdata_in[OVERRIDE_BIT]);
  COV_VOLT_WRITE: cover property (wr_volt ##2 reg_rd_in);
  COV_UNMAPPED_READ: cover property (reg_rd_in && reg_addr_in == 8'h07);
  COV_VOLT_CLAMP: cover property (charge_voltage_target_out == VOLT_MAX_MV);

endmodule : ccv_regs

// ---- test/ccv_host.sv ----
// ----------------------------------------------------------------
// Host side of the parallel register port
// ----------------------------------------------------------------
module ccv_host (
  input wire logic sys_clk_in,
  input wire logic [7:0] reg_rdata_in,
  output logic [7:0] reg_addr_out,
  output logic reg_wr_out,
  output logic [7:0] reg_wdata_out,
  output logic reg_rd_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import ccv_pkg::*;

  int idle_gap = 0; // Extra idle cycles before each request

  // Bus idle at time zero
  initial begin
    reg_addr_out = 8'h00;
    reg_wdata_out = 8'h00;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
  end

  // One write, released lines show inverted values
  task automatic wr_reg(input logic [7:0] addr, input logic [7:0] data);
    logic [7:0] d;
    d = data;
    if (addr === ADDR_FAST && d[7:2] > FAST_MAX_CODE) begin
      d[7:2] = FAST_MAX_CODE;
    end
    repeat (idle_gap + 1) @(posedge sys_clk_in);
    #1;
    reg_addr_out = addr;
    reg_wdata_out = d;
    reg_wr_out = 1'b1;
    @(posedge sys_clk_in);
    #1;
    reg_wr_out = 1'b0;
    reg_addr_out = ~addr;
    reg_wdata_out = ~d;
  endtask : wr_reg

  // One read, data taken just after the edge that samples the strobe
  task automatic rd_reg(input logic [7:0] addr, output logic [7:0] data);
    repeat (idle_gap + 1) @(posedge sys_clk_in);
    #1;
    reg_addr_out = addr;
    reg_rd_out = 1'b1;
    @(posedge sys_clk_in);
    #1;
    data = reg_rdata_in;
    reg_rd_out = 1'b0;
    reg_addr_out = ~addr;
  endtask : rd_reg
endmodule : ccv_host

// ---- test/ccv_regs_tb.sv ----
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin \
  num_errors++; \
  $display("CHECK FAILED t=%0t act=%h exp=%h", $time, a, e); end end

module ccv_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ccv_pkg::*;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr, wdata, rdata;
  logic wr, rd;
  logic [12:0] fast, pre, term, chgv, lowv;
  logic [8:0] rechg;
  logic [6:0] bcold;
  int num_errors = 0;
  int total_checks = 0;
  logic [7:0] ra[4] = '{8'h02, 8'h03, 8'h04, 8'h03};
  logic [7:0] rv[4] = '{8'h5A, 8'h08, 8'hFF, 8'hF7};
  logic [5:0] fc[3] = '{6'h00, 6'h01, 6'h27};
  logic [3:0] pc[4] = '{4'h0, 4'h1, 4'h5, 4'hF};
  logic [12:0] pe[4] = '{13'h0080, 13'h0080, 13'h0300, 13'h0800};
  logic [7:0] vw[4] = '{8'h03, 8'hE0, 8'hDC, 8'hFC};
  logic [12:0] ve[4] = '{13'h0DB0, 13'h1130, 13'h1120, 13'h1130};
  logic [12:0] le[4] = '{13'h0BB8, 13'h0AF0, 13'h0AF0, 13'h0AF0};
  logic [8:0] ce[4] = '{9'h12C, 9'h064, 9'h064, 9'h064};

  // Clock
  always #10 clk = ~clk;

  ccv_host i_host (.sys_clk_in(clk), .reg_rdata_in(rdata),
    .reg_addr_out(addr), .reg_wr_out(wr), .reg_wdata_out(wdata),
    .reg_rd_out(rd));

  ccv_regs i_dut (.sys_clk_in(clk), .rst_n_in(rst_n), .reg_addr_in(addr),
    .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .fast_chg_current_target_out(fast),
    .precharge_current_target_out(pre),
    .termination_current_target_out(term),
    .charge_voltage_target_out(chgv), .low_batt_thresh_out(lowv),
    .recharge_offset_out(rechg), .boost_cold_thresh_pct_out(bcold));

  // Read and compare
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    i_host.rd_reg(a, d);
    `CHK(d, e)
  endtask : rd_chk

  // Write, then wait until targets show the decode
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    i_host.wr_reg(a, d);
    repeat (2) @(posedge clk);
    #1;
  endtask : put

  // Counts and verdict
  task automatic summarize();
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize

  // Watchdog
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    summarize();
  end

  // Tests
  initial begin
    repeat (4) @(posedge clk);
    #1;
    rst_n = 1'b1;
    @(posedge clk);
    #1;
    `CHK(fast, 13'h0800)
    `CHK(pre, 13'h0080)
    `CHK(term, 13'h0100)
    `CHK(chgv, 13'h1070)
    `CHK(lowv, 13'h0BB8)
    `CHK(rechg, 9'h064)
    `CHK(bcold, 7'h4C)
    rd_chk(ADDR_FAST, 8'h60);
    rd_chk(ADDR_PRE, 8'h11);
    rd_chk(ADDR_VOLT, 8'hB2);
    i_host.wr_reg(8'h05, 8'h77);
    rd_chk(8'h05, 8'h00);
    rd_chk(8'h07, 8'h00);
    rd_chk(ADDR_FAST, 8'h60);
    // Write followed closely by a read of the same register
    i_host.wr_reg(ADDR_PRE, 8'hA3);
    rd_chk(ADDR_PRE, 8'hA3);
    i_host.wr_reg(ADDR_VOLT, 8'h5D);
    rd_chk(ADDR_VOLT, 8'h5D);
    i_host.idle_gap = 2;
    for (int i = 0; i < 4; i++) begin
      i_host.wr_reg(ra[i], rv[i]);
      rd_chk(ra[i], rv[i]);
    end
    i_host.idle_gap = 0;
    for (int i = 0; i < 3; i++) begin
      put(ADDR_FAST, {fc[i], 2'b00});
      `CHK(fast, 13'h0200 + 13'h0040 * {7'h00, fc[i]})
    end
    for (int i = 0; i < 8; i++) begin
      put(ADDR_PRE, {5'h02, 3'(i)});
      `CHK(term, 13'h0080 * 13'(i + 1))
    end
    for (int i = 0; i < 4; i++) begin
      put(ADDR_PRE, {pc[i], 4'h1});
      `CHK(pre, pe[i])
    end
    put(ADDR_FAST, 8'h9F);
    `CHK(fast, 13'h0259)
    `CHK(pre, 13'h0400)
    `CHK(bcold, 7'h4F)
    put(ADDR_PRE, 8'h51);
    `CHK(pre, 13'h0180)
    put(ADDR_FAST, 8'h9C);
    `CHK(fast, 13'h0BC0)
    `CHK(pre, 13'h0300)
    `CHK(bcold, 7'h4C)
    for (int i = 0; i < 4; i++) begin
      put(ADDR_VOLT, vw[i]);
      `CHK(chgv, ve[i])
      `CHK(lowv, le[i])
      `CHK(rechg, ce[i])
    end
    summarize();
  end
endmodule : ccv_regs_tb
